// >>> verilog/sbrd_read_cmd.sv
// serial boot-loader flash read command interpreter
`timescale 1ns/10ps
// Notes on behaviour
// - first sync byte 0x86/0x30 with good baud is echoed; otherwise silence
// - second sync byte 0x79/0xCF is echoed; mismatch is silent
// - read opcode 0x40 is acknowledged by echoing it
// - refused opcode sends an error code three times, then idles
// - blank top region skips password string; both addresses still needed
// - bad password address sends nothing; idle until reset
// - flash security enabled refuses the read and idles
// - link error during password phase idles until reset
// - zero or oversize byte count stops communication and idles
// - after last count byte, stream consecutive memory bytes
// - after data send 16-bit checksum high then low
// - after checksum, wait for next opcode
// - nothing is sent while address or count bytes are received
module sbrd_read_cmd import sbrd_pkg::*; #(
  parameter logic [23:0] MEM_SIZE = MEM_SIZE_DEF,
  parameter int BUF_DEPTH = BUF_DEPTH_DEF
) (
  input wire logic ref_clk, // core clock, 200 MHz
  input wire logic resetn, // async reset, active low
  input wire logic rxValid, // received byte strobe
  input wire logic [7:0] rxByte, // received byte
  input wire logic rxError, // framing/parity fault on this byte
  input wire logic baudOk, // baud measure succeeded on this byte
  input wire logic securityOn, // flash security enabled
  input wire logic topBlank, // top flash region all erased
  input wire logic [7:0] pwLen, // password length from flash
  input wire logic pwMatch, // password comparison result
  output logic pwStrobe, // password string byte on rxByte
  output logic memRd, // flash read request
  output logic [23:0] memAddr, // flash read address
  input wire logic [7:0] memData, // flash data, same cycle
  output logic txValid, // transmit byte available
  input wire logic txReady, // transmitter takes byte
  output logic [7:0] txData, // transmit byte
  output logic halted // session stopped until reset
);
  // ----------------------------------------------------------------
  // state and transmit staging
  // ----------------------------------------------------------------
  sbrd_state_t st_q, st_d;
  logic [7:0] idx_q, idx_d;
  logic [15:0] sh_q, sh_d;
  logic pend_q, pend_d;
  logic [7:0] pdat_q, pdat_d;
  logic [7:0] errCode_q, errCode_d;
  logic [1:0] errCnt_q, errCnt_d;
  logic [23:0] addr_q, addr_d;
  logic [23:0] left_q, left_d;
  logic [15:0] sum_q, sum_d;

  sbrd_buf_if #(.W(BYTE_W)) pushIf ();
  sbrd_buf_if #(.W(BYTE_W)) popIf ();

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire slotFree = !pend_q || pushIf.ready;
  wire goodRx = rxValid && !rxError;
  wire [23:0] word = {sh_q, rxByte};
  wire lastAdr = (idx_q == ADDR_LAST);
  wire isSync1 = (rxByte == SYNC1_A) || (rxByte == SYNC1_B);
  wire isSync2 = (rxByte == SYNC2_A) || (rxByte == SYNC2_B);
  wire adrBad = (word >= MEM_SIZE);
  wire cntBad = (word == 24'h000000) || (word > MEM_SIZE);
  wire inAddr = (st_q == ST_PCNT) || (st_q == ST_PCMP) || (st_q == ST_RADR) ||
                (st_q == ST_RCNT);
  wire inPw = (st_q == ST_PCNT) || (st_q == ST_PCMP) || (st_q == ST_PSTR);

  // staged byte feeds the buffer; buffer drains to the transmitter
  assign pushIf.valid = pend_q;
  assign pushIf.data = pdat_q;
  assign popIf.ready = txReady;
  assign txValid = popIf.valid;
  assign txData = popIf.data;
  assign pwStrobe = (st_q == ST_PSTR) && goodRx;
  assign memRd = (st_q == ST_DATA) && slotFree;
  assign memAddr = addr_q;
  assign halted = (st_q == ST_HALT);

  sbrd_buf #(.WIDTH(BYTE_W), .DEPTH(BUF_DEPTH)) u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .inp(pushIf),
    .outp(popIf)
  );

  // ----------------------------------------------------------------
  // session sequencer
  // ----------------------------------------------------------------
  // a byte that needs an answer is only taken while the staging slot is
  // free; at link byte rates the buffer is always drained by then
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    sh_d = sh_q;
    pend_d = pend_q && !pushIf.ready;
    pdat_d = pdat_q;
    errCode_d = errCode_q;
    errCnt_d = errCnt_q;
    addr_d = addr_q;
    left_d = left_q;
    sum_d = sum_q;
    case (st_q)
      ST_SYNC1: begin
        if (goodRx && baudOk && isSync1 && slotFree) begin
          pend_d = 1'h1;
          pdat_d = rxByte;
          st_d = ST_SYNC2;
        end
      end
      ST_SYNC2: begin
        if (rxValid) begin
          if (!rxError && isSync2 && slotFree) begin
            pend_d = 1'h1;
            pdat_d = rxByte;
            st_d = ST_CMD;
          end else begin
            st_d = ST_SYNC1;
          end
        end
      end
      ST_CMD: begin
        if (rxValid && slotFree) begin
          errCnt_d = '0;
          st_d = ST_ERR;
          idx_d = '0;
          if (rxError) errCode_d = ERR_COMM;
          else if (securityOn) errCode_d = ERR_SEC;
          else if (rxByte != OP_READ) errCode_d = ERR_CMD;
          else begin
            pend_d = 1'h1;
            pdat_d = rxByte;
            st_d = ST_PCNT;
          end
        end
      end
      ST_ERR: begin
        if (slotFree) begin
          pend_d = 1'h1;
          pdat_d = errCode_q;
          errCnt_d = errCnt_q + 2'h1;
          if (errCnt_q == ERR_REPEAT - 2'h1) st_d = ST_HALT;
        end
      end
      ST_PCNT, ST_PCMP, ST_RADR, ST_RCNT: begin
        // address and count bytes are collected silently
        if (rxValid && rxError) st_d = ST_HALT;
        else if (rxValid) begin
          sh_d = word[15:0];
          idx_d = lastAdr ? 8'h00 : idx_q + 8'h01;
          if (lastAdr) begin
            case (st_q)
              ST_PCNT: st_d = adrBad ? ST_HALT : ST_PCMP;
              ST_PCMP: begin
                if (adrBad) st_d = ST_HALT;
                else if (topBlank) st_d = ST_RADR;
                else if (pwLen == 8'h00) st_d = ST_HALT;
                else st_d = ST_PSTR;
              end
              ST_RADR: begin
                addr_d = word;
                st_d = adrBad ? ST_HALT : ST_RCNT;
              end
              default: begin
                left_d = word;
                sum_d = '0;
                st_d = cntBad ? ST_HALT : ST_DATA;
              end
            endcase
          end
        end
      end
      ST_PSTR: begin
        if (rxValid && rxError) st_d = ST_HALT;
        else if (rxValid) begin
          idx_d = idx_q + 8'h01;
          if (idx_q == pwLen - 8'h01) begin
            idx_d = '0;
            st_d = ST_PCHK;
          end
        end
      end
      ST_PCHK: st_d = pwMatch ? ST_RADR : ST_HALT;
      ST_DATA: begin
        if (slotFree) begin
          pend_d = 1'h1;
          pdat_d = memData;
          sum_d = sum_q + {8'h00, memData};
          addr_d = addr_q + 24'h000001;
          left_d = left_q - 24'h000001;
          if (left_q == 24'h000001) st_d = ST_SUMH;
        end
      end
      ST_SUMH: begin
        if (slotFree) begin
          pend_d = 1'h1;
          pdat_d = sum_q[15:8];
          st_d = ST_SUML;
        end
      end
      ST_SUML: begin
        if (slotFree) begin
          pend_d = 1'h1;
          pdat_d = sum_q[7:0];
          st_d = ST_CMD;
        end
      end
      ST_HALT: st_d = ST_HALT;
      default: st_d = ST_HALT;
    endcase
  end

  // registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_SYNC1;
      idx_q <= '0;
      sh_q <= '0;
      pend_q <= 1'h0;
      pdat_q <= '0;
      errCode_q <= '0;
      errCnt_q <= '0;
      addr_q <= '0;
      left_q <= '0;
      sum_q <= '0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      pend_q <= pend_d;
      pdat_q <= pdat_d;
      errCode_q <= errCode_d;
      errCnt_q <= errCnt_d;
      addr_q <= addr_d;
      left_q <= left_d;
      sum_q <= sum_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_sync1_echo;
    st_q == ST_SYNC1 && goodRx && baudOk && isSync1 && slotFree
      |=> pend_q && pdat_q == $past(rxByte) && st_q == ST_SYNC2;
  endproperty
  a_sync1_echo: assert property (p_sync1_echo)
    else $error("first sync byte not echoed");

  property p_sync2_bad;
    st_q == ST_SYNC2 && rxValid && !isSync2 |=> st_q == ST_SYNC1 && !$rose(pend_q);
  endproperty
  a_sync2_bad: assert property (p_sync2_bad)
    else $error("bad second sync byte not ignored");

  property p_cmd_ok;
    st_q == ST_CMD && goodRx && !securityOn && rxByte == OP_READ && slotFree
      |=> pend_q && pdat_q == OP_READ && st_q == ST_PCNT;
  endproperty
  a_cmd_ok: assert property (p_cmd_ok)
    else $error("read opcode not acknowledged");

  property p_err_three;
    st_q == ST_ERR && errCnt_q == 2'h2 && slotFree
      |=> st_q == ST_HALT && pend_q && pdat_q == $past(errCode_q);
  endproperty
  a_err_three: assert property (p_err_three)
    else $error("error code burst wrong");

  property p_halt_mute;
    st_q == ST_HALT && !pend_q |=> !pend_q [*2] ##0 st_q == ST_HALT;
  endproperty
  a_halt_mute: assert property (p_halt_mute)
    else $error("stopped session transmitted");

  property p_sec;
    st_q == ST_CMD && goodRx && securityOn && slotFree
      |=> st_q == ST_ERR && errCode_q == ERR_SEC ##3 st_q == ST_HALT;
  endproperty
  a_sec: assert property (p_sec)
    else $error("secured read not refused");

  property p_pw_comm;
    inPw && rxValid && rxError |=> st_q == ST_HALT;
  endproperty
  a_pw_comm: assert property (p_pw_comm)
    else $error("link error in password phase not stopped");

  property p_blank;
    st_q == ST_PCMP && goodRx && lastAdr && topBlank && !adrBad |=> st_q == ST_RADR;
  endproperty
  a_blank: assert property (p_blank)
    else $error("blank part did not skip password");

  property p_cnt_bad;
    st_q == ST_RCNT && goodRx && lastAdr && cntBad |=> st_q == ST_HALT;
  endproperty
  a_cnt_bad: assert property (p_cnt_bad)
    else $error("bad byte count accepted");

  property p_quiet;
    inAddr && !pend_q |=> !pend_q;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("byte sent during address phase");

  property p_data;
    st_q == ST_DATA && slotFree
      |=> pdat_q == $past(memData) && memAddr == $past(memAddr) + 24'h000001;
  endproperty
  a_data: assert property (p_data)
    else $error("memory stream out of order");

  property p_sum;
    st_q == ST_SUMH && slotFree |=> pdat_q == $past(sum_q[15:8]) && st_q == ST_SUML
      ##[1:8] st_q == ST_CMD && pdat_q == sum_q[7:0];
  endproperty
  a_sum: assert property (p_sum)
    else $error("checksum bytes wrong");

  property p_back;
    st_q == ST_SUML && slotFree |=> st_q == ST_CMD;
  endproperty
  a_back: assert property (p_back)
    else $error("no return to opcode wait");

  c_read_done: cover property (st_q == ST_SUML && slotFree);
  c_halt: cover property ($rose(st_q == ST_HALT));
  c_pw_path: cover property (st_q == ST_PCHK && pwMatch);
  c_stall: cover property (st_q == ST_DATA && !slotFree);
endmodule

// >>> verilog/sbrd_pkg.sv
// constants and types shared by the boot-loader read command block
package sbrd_pkg;
  // ----------------------------------------------------------------
  // link byte codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC1_A = 8'h86;
  localparam logic [7:0] SYNC1_B = 8'h30;
  localparam logic [7:0] SYNC2_A = 8'h79;
  localparam logic [7:0] SYNC2_B = 8'hCF;
  localparam logic [7:0] OP_READ = 8'h40;
  localparam logic [7:0] ERR_COMM = 8'hA1;
  localparam logic [7:0] ERR_CMD = 8'hA3;
  localparam logic [7:0] ERR_SEC = 8'h63;
  // ----------------------------------------------------------------
  // counts and sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] ERR_REPEAT = 2'h3;
  localparam logic [7:0] ADDR_LAST = 8'h02;
  localparam logic [23:0] MEM_SIZE_DEF = 24'h010000;
  localparam int BUF_DEPTH_DEF = 2;
  localparam int BYTE_W = 8;
  // ----------------------------------------------------------------
  // session states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SYNC1, ST_SYNC2, ST_CMD, ST_PCNT, ST_PCMP, ST_PSTR, ST_PCHK,
    ST_RADR, ST_RCNT, ST_DATA, ST_SUMH, ST_SUML, ST_ERR, ST_HALT
  } sbrd_state_t;
endpackage

// >>> verilog/sbrd_buf_if.sv
// valid/ready byte channel between the interpreter and its buffer
`timescale 1ns/10ps
interface sbrd_buf_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> verilog/sbrd_buf.sv
// small flip-flop fifo for transmit bytes
`timescale 1ns/10ps
module sbrd_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk, // core clock
  input wire logic resetn, // async reset, active low
  sbrd_buf_if.snk inp, // filling side
  sbrd_buf_if.src outp // draining side
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire doWr = inp.valid & inp.ready;
  wire doRd = outp.valid & outp.ready;
  wire [AW-1:0] wrNext = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'h1;
  wire [AW-1:0] rdNext = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'h1;

  // full and empty straight from the occupancy count
  assign inp.ready = (cnt_q != (AW+1)'(DEPTH));
  assign outp.valid = (cnt_q != '0);
  assign outp.data = mem_q[rd_q];

  // pointers and occupancy
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (doWr) wr_q <= wrNext;
      if (doRd) rd_q <= rdNext;
      if (doWr && !doRd) cnt_q <= cnt_q + 1'h1;
      else if (doRd && !doWr) cnt_q <= cnt_q - 1'h1;
    end
  end

  // storage needs no reset, it is never read while empty
  always_ff @(posedge ref_clk) begin
    if (doWr) mem_q[wr_q] <= inp.data;
  end
endmodule

// >>> verif/sbrd_ctl_model.sv
// behavioural programming controller and flash array facing the read command block
`timescale 1ns/10ps
module sbrd_ctl_model (
  input wire logic ref_clk, // core clock
  input wire logic hold, // controller not ready to take bytes
  output logic rxValid, // byte strobe to the block
  output logic [7:0] rxByte, // byte to the block
  output logic rxError, // link fault on this byte
  output logic baudOk, // baud measure result on this byte
  input wire logic txValid, // byte offered by the block
  input wire logic [7:0] txData, // offered byte
  output logic txReady, // controller takes the byte
  input wire logic [23:0] memAddr, // flash address
  output logic [7:0] memData // flash data
);
  // ----------------------------------------------------------------
  // link and flash behaviour
  // ----------------------------------------------------------------
  logic [7:0] got[$];
  initial begin
    rxValid = 1'b0;
    rxByte = 8'h00;
    rxError = 1'b0;
    baudOk = 1'b0;
    txReady = 1'b0;
  end
  // hashed contents so that an address slip changes the data seen
  assign memData = memAddr[7:0] ^ memAddr[15:8] ^ 8'h5A;
  // ready follows the stall request, changed away from the sampling edge
  always @(negedge ref_clk) txReady <= !hold;
  // every byte the block hands over, in order
  always @(posedge ref_clk) if (txValid && txReady) got.push_back(txData);
  // one byte per call; the gap stands for a slow serial link, so the echo slot is free
  task automatic send(input logic [7:0] b, input logic err, input logic baud);
    @(negedge ref_clk);
    rxValid = 1'b1;
    rxByte = b;
    rxError = err;
    baudOk = baud;
    @(negedge ref_clk);
    rxValid = 1'b0;
    rxByte = ~b; // released data line must not look like the last byte
    rxError = 1'b0;
    baudOk = 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the boot-loader read command block
`timescale 1ns/10ps
module testbench;
  import sbrd_pkg::*;
  // ----------------------------------------------------------------
  // clock, levels and the two parties
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic securityOn = 1'b0;
  logic topBlank = 1'b1;
  logic pwMatch = 1'b1;
  logic hold = 1'b0;
  logic [7:0] pwLen = 8'h02;
  logic pwStrobe, memRd, txValid, txReady, halted, rxValid, rxError, baudOk;
  logic [7:0] rxByte, memData, txData;
  logic [23:0] memAddr;
  int nFail = 0;
  int totalChecks = 0;
  int cycles = 0;
  int nStrobe = 0;
  int nMemRd = 0;
  always #2.5 ref_clk = ~ref_clk;
  sbrd_read_cmd #(.MEM_SIZE(MEM_SIZE_DEF), .BUF_DEPTH(BUF_DEPTH_DEF)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .rxValid(rxValid), .rxByte(rxByte),
    .rxError(rxError), .baudOk(baudOk), .securityOn(securityOn), .topBlank(topBlank),
    .pwLen(pwLen), .pwMatch(pwMatch), .pwStrobe(pwStrobe), .memRd(memRd),
    .memAddr(memAddr), .memData(memData), .txValid(txValid), .txReady(txReady),
    .txData(txData), .halted(halted));
  sbrd_ctl_model ctl (
    .ref_clk(ref_clk), .hold(hold), .rxValid(rxValid), .rxByte(rxByte),
    .rxError(rxError), .baudOk(baudOk), .txValid(txValid), .txData(txData),
    .txReady(txReady), .memAddr(memAddr), .memData(memData));
  // a hung handshake must still end in the verdict
  always @(posedge ref_clk) begin
    cycles++;
    // pulses of the password strobe and of the flash read request
    if (pwStrobe) nStrobe++;
    if (memRd) nMemRd++;
    if (cycles == 20000) begin
      nFail++;
      giveVerdict();
    end
  end
  // ----------------------------------------------------------------
  // compare and transfer helpers
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  // waits a bounded time for the bytes, then a little more to catch extra ones
  task automatic expect_tx(input logic [7:0] exp[$]);
    int i;
    i = 0;
    while (ctl.got.size() < exp.size() && i < 400) begin
      @(negedge ref_clk);
      i++;
    end
    repeat (10) @(negedge ref_clk);
    chk8(8'(ctl.got.size()), 8'(exp.size()));
    foreach (exp[k]) chk8(k < ctl.got.size() ? ctl.got[k] : 8'hXX, exp[k]);
    ctl.got.delete();
  endtask
  task automatic send24(input logic [23:0] v);
    for (int j = 0; j < 3; j++) ctl.send(8'(v >> (16 - 8 * j)), 1'b0, 1'b0);
  endtask
  task automatic do_reset();
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    ctl.got.delete();
    chk1(halted, 1'b0);
  endtask
  task automatic open_session(input logic [7:0] s1, input logic [7:0] s2);
    ctl.send(s1, 1'b0, 1'b1);
    expect_tx('{s1});
    ctl.send(s2, 1'b0, 1'b0);
    expect_tx('{s2});
    ctl.send(OP_READ, 1'b0, 1'b0);
    expect_tx('{OP_READ});
  endtask
  task automatic pw_addrs();
    send24(24'h00FFE0);
    send24(24'h00FFE0);
  endtask
  // read address and count, then the data stream and its sum
  task automatic read_block(input logic [23:0] ra, input logic [23:0] cnt, input logic stall);
    logic [7:0] exp[$];
    logic [15:0] sum;
    logic [23:0] a;
    sum = 16'h0000;
    nMemRd = 0;
    send24(ra);
    expect_tx('{});
    hold = stall;
    send24(cnt);
    if (stall) begin
      repeat (40) @(negedge ref_clk);
      chk8(8'(ctl.got.size()), 8'h00);
      chk1(txValid, 1'b1);
      hold = 1'b0;
    end
    for (int i = 0; i < cnt; i++) begin
      a = ra + 24'(i);
      exp.push_back(a[7:0] ^ a[15:8] ^ 8'h5A);
      sum = sum + 16'(exp[i]);
    end
    exp.push_back(sum[15:8]);
    exp.push_back(sum[7:0]);
    expect_tx(exp);
    chk8(8'(nMemRd), cnt[7:0]);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_blank_read();
    topBlank = 1'b1;
    do_reset();
    open_session(SYNC1_A, SYNC2_A);
    pw_addrs();
    read_block(24'h0000FE, 24'h000005, 1'b0);
    ctl.send(OP_READ, 1'b0, 1'b0);
    expect_tx('{OP_READ});
    pw_addrs();
    read_block(24'h00FFFC, 24'h000004, 1'b1);
  endtask
  task automatic t_sync_refuse();
    do_reset();
    ctl.send(SYNC1_A, 1'b0, 1'b0);
    expect_tx('{});
    ctl.send(8'h55, 1'b0, 1'b1);
    expect_tx('{});
    ctl.send(SYNC1_B, 1'b0, 1'b1);
    expect_tx('{SYNC1_B});
    ctl.send(8'h12, 1'b0, 1'b0);
    expect_tx('{});
    open_session(SYNC1_B, SYNC2_B);
  endtask
  task automatic t_password(input logic match);
    topBlank = 1'b0;
    pwMatch = match;
    do_reset();
    open_session(SYNC1_B, SYNC2_A);
    pw_addrs();
    nStrobe = 0;
    ctl.send(8'h3C, 1'b0, 1'b0);
    ctl.send(8'hC3, 1'b0, 1'b0);
    chk8(8'(nStrobe), pwLen);
    if (match) begin
      read_block(24'h000100, 24'h000002, 1'b0);
    end else begin
      expect_tx('{});
      chk1(halted, 1'b1);
    end
    topBlank = 1'b1;
  endtask
  task automatic t_op_errors();
    logic [7:0] codes [3] = '{ERR_COMM, ERR_SEC, ERR_CMD};
    for (int k = 0; k < 3; k++) begin
      securityOn = (k == 1);
      do_reset();
      ctl.send(SYNC1_A, 1'b0, 1'b1);
      ctl.send(SYNC2_B, 1'b0, 1'b0);
      expect_tx('{SYNC1_A, SYNC2_B});
      ctl.send(k == 2 ? 8'h41 : OP_READ, k == 0, 1'b0);
      expect_tx('{codes[k], codes[k], codes[k]});
      chk1(halted, 1'b1);
      ctl.send(SYNC1_A, 1'b0, 1'b1);
      expect_tx('{});
    end
    securityOn = 1'b0;
  endtask
  // bad password address, link fault, zero and oversize counts
  task automatic t_halt_cases();
    logic [23:0] v [4];
    for (int k = 0; k < 4; k++) begin
      v = '{24'h00FFE0, 24'h00FFE0, 24'h000000, 24'h000004};
      if (k == 0) v[0] = MEM_SIZE_DEF;
      if (k == 2) v[3] = 24'h000000;
      if (k == 3) v[3] = MEM_SIZE_DEF + 24'h000001;
      do_reset();
      open_session(SYNC1_A, SYNC2_B);
      for (int j = 0; j < 12; j++) begin
        ctl.send(8'(v[j / 3] >> (16 - 8 * (j % 3))), k == 1 && j == 4, 1'b0);
      end
      expect_tx('{});
      chk1(halted, 1'b1);
    end
  endtask
  task automatic giveVerdict();
    if (nFail == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    t_blank_read();
    t_sync_refuse();
    t_password(1'b1);
    t_password(1'b0);
    t_op_errors();
    t_halt_cases();
    giveVerdict();
  end
endmodule
